// file: design/smc_pkg.sv
// Package with modes, codes, timing constants and carrier structs for the mode controller.
package smc_pkg;

    // Operating modes of the controller.
    typedef enum logic [2:0] {
        MODE_STARTUP,
        MODE_RESTART,
        MODE_NORMAL,
        MODE_STANDBY,
        MODE_SLEEP,
        MODE_FLASH,
        MODE_FAILSAFE
    } mode_t;

    // Watchdog behaviour selected per mode.
    typedef enum logic [1:0] {
        WD_STARTUP,
        WD_WINDOW,
        WD_TIMEOUT,
        WD_OFF
    } wd_mode_t;

    // Reset source codes recorded on each entry to start-up.
    typedef enum logic [3:0] {
        SRC_POWER_ON,
        SRC_WRONG_CODE,
        SRC_WD_TRIGGER,
        SRC_IRQ_IGNORED,
        SRC_FLASH_ENTRY,
        SRC_SLEEP_PENDING,
        SRC_WAKE,
        SRC_WD_OVERFLOW,
        SRC_AUX_OVERLOAD,
        SRC_CURRENT_RISE,
        SRC_EXT_RESET,
        SRC_FAILSAFE_EXIT
    } reset_src_t;

    // Mode-register codes, three bits wide.
    localparam logic [2:0] CODE_INIT_NORMAL = 3'h5;
    localparam logic [2:0] CODE_INIT_FLASH = 3'h3;
    localparam logic [2:0] CODE_FLASH_A = 3'h7;
    localparam logic [2:0] CODE_FLASH_B = 3'h1;
    localparam logic [2:0] CODE_NORMAL = 3'h2;
    localparam logic [2:0] CODE_STANDBY = 3'h4;
    localparam logic [2:0] CODE_SLEEP = 3'h6;
    localparam logic [2:0] CODE_FLASH_SERVE = 3'h7;

    // Required serial clock count of one SPI access.
    localparam logic [4:0] SPI_BITS = 5'h10;

    // Interrupt response time and clock rate.
    localparam int IRQ_RESP_MS = 256;
    localparam int CLK_HZ = 25000000;
    localparam int IRQ_RESP_CYC = IRQ_RESP_MS * (CLK_HZ / 1000);
    localparam int IRQ_CNT_W = 23;

    // Flash entry sequence progress width.
    localparam int FSEQ_W = 2;

    // Decoded mode-register write from the SPI front end.
    typedef struct packed {
        logic wr;
        logic [2:0] code;
        logic code_valid;
        logic [4:0] sck_count;
    } mode_wr_t;

    // Watchdog events reported by the watchdog timer.
    typedef struct packed {
        logic too_early;
        logic too_late;
        logic overflow;
        logic startup_expired;
    } wd_evt_t;

    // Wake sources and supply monitors.
    typedef struct packed {
        logic can_act;
        logic lin_act;
        logic wake_fall;
        logic aux_overload;
        logic aux_active;
        logic mcu_uv;
        logic icc_low;
    } wake_evt_t;

endpackage : smc_pkg

// file: design/smc_sync.sv
// Two-flop synchroniser with falling-edge detect on the second stage.
`timescale 1ns/100ps
`default_nettype none
module smc_sync
    import smc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic d_i,
    output logic q_o,
    output logic fall_o
);
    // Synchroniser and edge state as one struct.
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_st_t;

    sync_st_t st;
    sync_st_t next_st;

    // Only the second stage feeds the edge detector; the first is never read elsewhere.
    always_comb begin
        next_st = st;
        next_st.s1 = d_i;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    // Reset to high so a line held high does not show a false edge; the echo of the
    // controller's own reset pulse is masked by the controller, not here.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st <= '1;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign q_o = st.s2;
    assign fall_o = st.s3 & ~st.s2;
endmodule : smc_sync
`default_nettype wire

// file: design/smc_irq_timer.sv
// Interrupt response timer: counts from a raised interrupt until the host reads.
`timescale 1ns/100ps
`default_nettype none
module smc_irq_timer
    import smc_pkg::*;
#(
    parameter int RESP_CYC = IRQ_RESP_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic arm_i,
    input wire logic ack_i,
    input wire logic clear_i,
    output logic expired_o
);
    // Timer state.
    typedef struct packed {
        logic busy;
        logic [IRQ_CNT_W-1:0] cnt;
    } tmr_st_t;

    tmr_st_t st;
    tmr_st_t next_st;

    // An acknowledge stops the count; a fresh interrupt re-arms it.
    always_comb begin
        next_st = st;
        if (clear_i) begin
            next_st = '0;
        end else if (ack_i) begin
            next_st = '0;
        end else if (arm_i && !st.busy) begin
            next_st.busy = 1'b1;
            next_st.cnt = '0;
        end else if (st.busy && st.cnt != IRQ_CNT_W'(RESP_CYC - 1)) begin
            next_st.cnt = st.cnt + 1'b1;
        end
    end

    // Timer register.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign expired_o = st.busy && (st.cnt == IRQ_CNT_W'(RESP_CYC - 1));
endmodule : smc_irq_timer
`default_nettype wire

// file: design/system_mode_controller.sv
// Fail-safe system mode controller: mode sequencing, reset, supply and watchdog selection.
`timescale 1ns/100ps
`default_nettype none
module system_mode_controller
    import smc_pkg::*;
#(
    parameter int RESP_CYC = IRQ_RESP_CYC
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire mode_wr_t mode_wr_i,
    input wire wd_evt_t wd_evt_i,
    input wire wake_evt_t wake_evt_i,
    input wire logic host_reset_line_n_i,
    input wire logic int_read_i,
    input wire logic can_mode_set_i,
    input wire logic wd_off_opt_i,
    input wire logic cur_rise_reset_opt_i,
    input wire logic wake_reset_opt_i,
    input wire logic wd_overflow_irq_select_set_i,
    input wire logic wd_enabled_sleep_i,
    input wire logic osc_fail_i,
    output logic host_reset_line_n_o,
    output logic host_reset_line_n_oe_n_o,
    output logic mcu_supply_rail_o,
    output logic external_supply_switch_out_o,
    output logic external_supply_switch_out_oe_n_o,
    output logic can_mode_o,
    output logic irq_o,
    output logic long_reset_o,
    output wd_mode_t wd_mode_o,
    output logic wd_max_period_o,
    output logic wd_overflow_irq_select_o,
    output mode_t mode_o,
    output reset_src_t reset_src_o,
    output logic flash_prepared_o
);
    // Whole controller state in one struct; every output but the two constant pin drive levels comes from one of its fields.
    typedef struct packed {
        mode_t mode;
        reset_src_t src;
        logic long_rst;
        logic rst_drive;
        logic rail;
        logic inh_float;
        logic can_mode;
        logic irq;
        wd_mode_t wd;
        logic wd_max;
        logic wd_overflow_irq_select;
        logic [FSEQ_W-1:0] fseq;
        logic fprep;
        logic [1:0] echo; // Masks the late echo of our own pulse.
    } ctl_st_t;

    ctl_st_t st;
    ctl_st_t next_st;

    logic host_reset_line_n_sync; // Reset line after the synchroniser.
    logic host_reset_line_n_fall; // Falling edge of that line.
    logic irq_expired; // Interrupt response time has run out.
    logic wake_any; // Any bus or local wake event.
    logic tmr_clear; // Timer clears whenever a reset-driving mode is entered.

    // Valid-code, invalid-code and wrong-clock-count writes.
    logic wr_ok;
    logic wr_bad;
    logic spi_bad;

    // The reset pin arrives from the host side, so it is synchronised first.
    smc_sync u_host_reset_line_n_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .d_i(host_reset_line_n_i),
        .q_o(host_reset_line_n_sync),
        .fall_o(host_reset_line_n_fall)
    );

    // Tracks raised interrupts in Normal, Standby and Flash until the host reads them.
    smc_irq_timer #(.RESP_CYC(RESP_CYC)) u_irq_timer (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .arm_i(st.irq),
        .ack_i(int_read_i),
        .clear_i(tmr_clear),
        .expired_o(irq_expired)
    );

    // Decode helpers shared by the mode logic.
    always_comb begin
        wr_ok = mode_wr_i.wr && mode_wr_i.code_valid;
        wr_bad = mode_wr_i.wr && !mode_wr_i.code_valid;
        spi_bad = mode_wr_i.wr && (mode_wr_i.sck_count != SPI_BITS);
        wake_any = wake_evt_i.can_act | wake_evt_i.lin_act | wake_evt_i.wake_fall;
        tmr_clear = st.rst_drive || !(st.mode == MODE_NORMAL || st.mode == MODE_STANDBY
                                      || st.mode == MODE_FLASH);
    end

    // Mode sequencing; each branch chooses the next mode and the outputs that go with it.
    always_comb begin
        next_st = st;
        // Reset driver releases once the pin has had its pulse; pulse length lives outside.
        next_st.echo = st.rst_drive ? '1 : (st.echo == '0 ? '0 : st.echo - 1'b1);
        if (st.rst_drive && (st.mode == MODE_STARTUP || st.mode == MODE_RESTART)) begin
            next_st.rst_drive = 1'b0;
        end
        // Interrupt request is a level until the host reads the interrupt register.
        if (int_read_i) begin
            next_st.irq = 1'b0;
        end
        case (st.mode)
            MODE_STARTUP: begin
                next_st.wd = WD_STARTUP;
                next_st.rail = 1'b1;
                next_st.inh_float = 1'b0;
                if (wr_ok && !spi_bad && mode_wr_i.code == CODE_INIT_NORMAL) begin
                    next_st.mode = MODE_NORMAL;
                    next_st.fprep = 1'b0;
                    next_st.can_mode = 1'b0;
                    next_st.wd = WD_WINDOW;
                    next_st.long_rst = 1'b0;
                end else if (wr_ok && !spi_bad && mode_wr_i.code == CODE_INIT_FLASH
                             && st.fprep) begin
                    next_st.mode = MODE_FLASH;
                    next_st.fprep = 1'b0;
                    next_st.wd = WD_TIMEOUT;
                end else if (spi_bad) begin
                    next_st.mode = MODE_RESTART;
                    next_st.long_rst = 1'b1;
                    next_st.rst_drive = 1'b1;
                end else if (mode_wr_i.wr || wd_evt_i.startup_expired) begin
                    // Any code other than the two init codes is an initialization failure.
                    next_st.mode = MODE_RESTART;
                    next_st.long_rst = 1'b1;
                    next_st.rst_drive = 1'b1;
                end else if (host_reset_line_n_fall && st.echo == '0) begin
                    next_st.mode = MODE_RESTART;
                    next_st.long_rst = 1'b1;
                    next_st.rst_drive = 1'b1;
                end
            end
            MODE_RESTART: begin
                next_st.wd = WD_STARTUP;
                if (wr_ok && !spi_bad && mode_wr_i.code == CODE_INIT_NORMAL) begin
                    next_st.mode = MODE_NORMAL;
                    next_st.can_mode = 1'b0;
                    next_st.wd = WD_WINDOW;
                    next_st.fprep = 1'b0;
                end else if (mode_wr_i.wr || wd_evt_i.startup_expired
                             || (host_reset_line_n_fall && st.echo == '0)
                             || (host_reset_line_n_sync && wake_evt_i.mcu_uv)) begin
                    // A second failure ends in fail-safe, rail off, lowest power.
                    next_st.mode = MODE_FAILSAFE;
                    next_st.rail = 1'b0;
                    next_st.rst_drive = 1'b1;
                    next_st.wd = WD_OFF;
                end
            end
            MODE_NORMAL: begin
                next_st.wd = WD_WINDOW;
                next_st.can_mode = st.can_mode | can_mode_set_i;
                if (wr_ok && mode_wr_i.code == CODE_FLASH_A) begin
                    next_st.fseq = (st.fseq == 2'h2) ? 2'h3 : 2'h1;
                end else if (wr_ok && mode_wr_i.code == CODE_FLASH_B && st.fseq == 2'h1) begin
                    next_st.fseq = 2'h2;
                end else if (mode_wr_i.wr) begin
                    next_st.fseq = '0;
                end
                if (wr_bad) begin
                    next_st.src = SRC_WRONG_CODE;
                end else if (wd_evt_i.too_early || wd_evt_i.too_late) begin
                    next_st.src = SRC_WD_TRIGGER;
                end else if (irq_expired) begin
                    next_st.src = SRC_IRQ_IGNORED;
                end else if (wr_ok && mode_wr_i.code == CODE_FLASH_A && st.fseq == 2'h2) begin
                    next_st.src = SRC_FLASH_ENTRY;
                    next_st.fprep = 1'b1;
                end else if (wr_ok && mode_wr_i.code == CODE_SLEEP && st.irq) begin
                    next_st.src = SRC_SLEEP_PENDING;
                end else if (wr_ok && mode_wr_i.code == CODE_SLEEP) begin
                    next_st.mode = MODE_SLEEP;
                end else if (wr_ok && mode_wr_i.code == CODE_STANDBY) begin
                    next_st.mode = MODE_STANDBY;
                    next_st.can_mode = 1'b0;
                    next_st.wd_max = wd_off_opt_i;
                end else if (!host_reset_line_n_sync) begin
                    next_st.src = SRC_EXT_RESET;
                end
                // A reset source latched above sends the controller to start-up; flash entry and sleep pending do so only when they change the stored source.
                if (next_st.src != st.src || (wr_bad || wd_evt_i.too_early || wd_evt_i.too_late
                    || irq_expired || !host_reset_line_n_sync)) begin
                    if (next_st.mode == MODE_NORMAL) begin
                        next_st.mode = MODE_STARTUP;
                        next_st.rst_drive = 1'b1;
                        next_st.can_mode = 1'b0;
                        next_st.fseq = '0;
                    end
                end
            end
            MODE_STANDBY: begin
                next_st.can_mode = 1'b0;
                // Below the current limit the watchdog may stop when the option is set.
                if (wd_off_opt_i && wake_evt_i.icc_low) begin
                    next_st.wd = WD_OFF;
                end else begin
                    next_st.wd = WD_TIMEOUT;
                end
                if (wd_off_opt_i && st.wd == WD_OFF && !wake_evt_i.icc_low) begin
                    next_st.wd_max = 1'b1;
                end
                // The select bit is set by software and cleared by each overflow; set wins.
                if (wd_overflow_irq_select_set_i) begin
                    next_st.wd_overflow_irq_select = 1'b1;
                end else if (wd_evt_i.overflow) begin
                    next_st.wd_overflow_irq_select = 1'b0;
                end
                if (wr_bad) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.src = SRC_WRONG_CODE;
                end else if (irq_expired) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.src = SRC_IRQ_IGNORED;
                end else if (wd_evt_i.overflow && !st.wd_overflow_irq_select) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.src = SRC_WD_OVERFLOW;
                end else if (wd_evt_i.overflow) begin
                    next_st.irq = 1'b1;
                end else if (wake_any && wake_reset_opt_i) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.src = SRC_WAKE;
                end else if (wake_any) begin
                    next_st.irq = 1'b1;
                end else if (st.wd == WD_OFF && !wake_evt_i.icc_low && cur_rise_reset_opt_i) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.src = SRC_CURRENT_RISE;
                end else if (!host_reset_line_n_sync) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.src = SRC_EXT_RESET;
                end else if (wr_ok && mode_wr_i.code == CODE_NORMAL) begin
                    next_st.mode = MODE_NORMAL;
                    next_st.wd = WD_WINDOW;
                    next_st.wd_max = 1'b0;
                end else if (wr_ok && mode_wr_i.code == CODE_SLEEP) begin
                    next_st.mode = MODE_SLEEP;
                end
                if (next_st.mode == MODE_STARTUP) begin
                    next_st.rst_drive = 1'b1;
                    next_st.wd_max = 1'b0;
                end
            end
            MODE_SLEEP: begin
                // Sleep-entry pins are set after the case; here the exits, which restore rail and switch on leaving.
                next_st.can_mode = 1'b0;
                next_st.wd = wd_enabled_sleep_i ? WD_TIMEOUT : WD_OFF;
                if (wd_evt_i.overflow && wd_enabled_sleep_i) begin
                    next_st.src = SRC_WD_OVERFLOW;
                    next_st.mode = MODE_STARTUP;
                end else if (wake_any) begin
                    next_st.src = SRC_WAKE;
                    next_st.mode = MODE_STARTUP;
                end else if (wake_evt_i.aux_overload && wake_evt_i.aux_active) begin
                    next_st.src = SRC_AUX_OVERLOAD;
                    next_st.mode = MODE_STARTUP;
                end
                if (next_st.mode == MODE_STARTUP) begin
                    next_st.rail = 1'b1;
                    next_st.inh_float = 1'b0;
                end
            end
            MODE_FLASH: begin
                next_st.wd = WD_TIMEOUT;
                if ((mode_wr_i.wr && (!mode_wr_i.code_valid
                     || mode_wr_i.code != CODE_FLASH_SERVE)) || wd_evt_i.overflow
                     || irq_expired) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.rst_drive = 1'b1;
                    next_st.src = wd_evt_i.overflow ? SRC_WD_OVERFLOW
                                : (irq_expired ? SRC_IRQ_IGNORED : SRC_WRONG_CODE);
                end
            end
            MODE_FAILSAFE: begin
                // Leave only on a wake with a healthy oscillator, with the long pulse.
                next_st.wd = WD_OFF;
                if (wake_any && !osc_fail_i) begin
                    next_st.mode = MODE_STARTUP;
                    next_st.src = SRC_FAILSAFE_EXIT;
                    next_st.long_rst = 1'b1;
                    next_st.rail = 1'b1;
                    next_st.rst_drive = 1'b1;
                end
            end
            default: begin
                next_st.mode = MODE_FAILSAFE;
            end
        endcase
        // Sleep pins change on the entering edge.
        if (next_st.mode == MODE_SLEEP) begin
            next_st.rst_drive = 1'b1;
            next_st.rail = 1'b0;
            next_st.inh_float = 1'b1;
        end
        // Oscillator failure overrides every mode.
        if (osc_fail_i) begin
            next_st.mode = MODE_FAILSAFE;
            next_st.rail = 1'b0;
            next_st.rst_drive = 1'b1;
            next_st.wd = WD_OFF;
        end
    end

    // State register; transitions occur only on the oscillator clock edge.
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            st <= '0;
            st.mode <= MODE_STARTUP;
            st.src <= SRC_POWER_ON;
            st.long_rst <= 1'b1;
            st.rst_drive <= 1'b1;
            st.rail <= 1'b1;
            st.wd <= WD_STARTUP;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // Open-drain reset pin: enable low means the pin is pulled low.
    assign host_reset_line_n_o = 1'b0;
    assign host_reset_line_n_oe_n_o = ~st.rst_drive;
    assign mcu_supply_rail_o = st.rail;
    assign external_supply_switch_out_o = 1'b1;
    assign external_supply_switch_out_oe_n_o = st.inh_float;
    assign can_mode_o = st.can_mode;
    assign irq_o = st.irq;
    assign long_reset_o = st.long_rst;
    assign wd_mode_o = st.wd;
    assign wd_max_period_o = st.wd_max;
    assign wd_overflow_irq_select_o = st.wd_overflow_irq_select;
    assign mode_o = st.mode;
    assign reset_src_o = st.src;
    assign flash_prepared_o = st.fprep;
endmodule : system_mode_controller
`default_nettype wire

// file: testbench/system_mode_controller_props.sv
// Port assertions and covers for the system mode controller.
`timescale 1ns/100ps
`default_nettype none
module system_mode_controller_props
    import smc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire mode_wr_t mode_wr_i,
    input wire wd_evt_t wd_evt_i,
    input wire logic osc_fail_i,
    input wire logic host_reset_line_n_oe_n_o,
    input wire logic mcu_supply_rail_o,
    input wire logic external_supply_switch_out_oe_n_o,
    input wire logic can_mode_o,
    input wire logic long_reset_o,
    input wire wd_mode_t wd_mode_o,
    input wire mode_t mode_o,
    input wire reset_src_t reset_src_o
);
    // One clock domain, so clock and reset are stated once.
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // Pulses only count while the clock enable runs and the oscillator is sound.
    wire run = ce_i && !osc_fail_i;
    wire wr_ok = mode_wr_i.wr && mode_wr_i.code_valid && mode_wr_i.sck_count == SPI_BITS;
    chk_init_to_normal: assert property (run && mode_o == MODE_STARTUP && wr_ok && wd_evt_i == '0
        && mode_wr_i.code == CODE_INIT_NORMAL |=> mode_o == MODE_NORMAL)
        else $error("init code did not reach normal");
    chk_sck_restart: assert property (run && mode_o == MODE_STARTUP && mode_wr_i.wr
        && mode_wr_i.sck_count != SPI_BITS |=> mode_o == MODE_RESTART)
        else $error("bad clock count did not restart");
    chk_restart_long: assert property (mode_o == MODE_RESTART |-> long_reset_o)
        else $error("restart without long reset");
    chk_normal_window: assert property (mode_o == MODE_NORMAL |-> wd_mode_o == WD_WINDOW)
        else $error("normal without window watchdog");
    chk_wd_fault_reset: assert property (run && mode_o == MODE_NORMAL && !mode_wr_i.wr
        && (wd_evt_i.too_early || wd_evt_i.too_late) |=> mode_o == MODE_STARTUP
        && reset_src_o == SRC_WD_TRIGGER)
        else $error("watchdog fault not reset");
    chk_standby_can: assert property (mode_o == MODE_STANDBY && $past(mode_o) != MODE_STANDBY
        |-> !can_mode_o)
        else $error("can bit kept in standby");
    chk_sleep_pins: assert property (mode_o == MODE_SLEEP |-> !mcu_supply_rail_o
        && !host_reset_line_n_oe_n_o && external_supply_switch_out_oe_n_o)
        else $error("sleep pins wrong");
    chk_sleep_source: assert property (mode_o == MODE_SLEEP && $past(mode_o) != MODE_SLEEP
        |-> $past(mode_o) inside {MODE_NORMAL, MODE_STANDBY})
        else $error("sleep from illegal mode");
    chk_reset_start: assert property ($fell(rst_i) |-> mode_o == MODE_STARTUP && long_reset_o)
        else $error("reset did not start up");
    cov_normal: cover property (mode_o == MODE_NORMAL);
    cov_restart: cover property (mode_o == MODE_RESTART);
    cov_sleep: cover property (mode_o == MODE_SLEEP);
endmodule : system_mode_controller_props
bind system_mode_controller system_mode_controller_props u_props (.*);
`default_nettype wire

// file: testbench/host_mcu_model.sv
// Host microcontroller model: mode-register writes and the open-drain reset line.
`timescale 1ns/100ps
`default_nettype none
module host_mcu_model
    import smc_pkg::*;
(
    input wire logic mclk_i,
    input wire logic req_i,
    input wire logic [2:0] code_i,
    input wire logic [4:0] sck_i,
    input wire logic pull_low_i,
    input wire logic oe_n_i,
    output logic line_o,
    output mode_wr_t mode_wr_o
);
    // A finished SPI frame shows as a one-cycle write pulse with its clock count.
    always @(posedge mclk_i) begin
        mode_wr_o <= '{wr: req_i, code: code_i, code_valid: 1'b1, sck_count: sck_i};
    end
    // The line has a pull-up, so it is low only while a party pulls it.
    assign line_o = !(pull_low_i || !oe_n_i);
endmodule : host_mcu_model
`default_nettype wire

// file: testbench/system_mode_controller_tb.sv
// Self-checking bench for the system mode controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin failures++; \
    $display("wrong value %s exp %0h got %0h", n, e, s); end end
module system_mode_controller_tb
    import smc_pkg::*;
;
    logic mclk_i = 0, rst_i = 1, req = 0, pull = 0, can_set = 0, oe_n, rail, ext_oe, can, lr, line;
    logic [2:0] code = 0;
    logic [4:0] sck = 5'h10;
    logic [3:0] opt = 0; // Random option levels; they change only under reset.
    wd_evt_t wd = '0;
    wake_evt_t wk = '0;
    mode_wr_t wr;
    wd_mode_t wdm;
    mode_t mode;
    reset_src_t src;
    logic fp, wmax;
    int failures = 0, n_tests = 0, cyc = 0;
    host_mcu_model host (.mclk_i(mclk_i), .req_i(req), .code_i(code), .sck_i(sck),
        .pull_low_i(pull), .oe_n_i(oe_n), .line_o(line), .mode_wr_o(wr));
    system_mode_controller #(.RESP_CYC(20)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_i(1'b1),
        .mode_wr_i(wr), .wd_evt_i(wd), .wake_evt_i(wk), .host_reset_line_n_i(line),
        .int_read_i(1'b0), .can_mode_set_i(can_set), .wd_off_opt_i(opt[0]),
        .cur_rise_reset_opt_i(opt[1]), .wake_reset_opt_i(opt[2]),
        .wd_overflow_irq_select_set_i(1'b0), .wd_enabled_sleep_i(opt[3]), .osc_fail_i(1'b0),
        .host_reset_line_n_o(), .host_reset_line_n_oe_n_o(oe_n), .mcu_supply_rail_o(rail),
        .external_supply_switch_out_o(), .external_supply_switch_out_oe_n_o(ext_oe),
        .can_mode_o(can), .irq_o(), .long_reset_o(lr), .wd_mode_o(wdm), .wd_max_period_o(wmax),
        .wd_overflow_irq_select_o(), .mode_o(mode), .reset_src_o(src), .flash_prepared_o(fp));
    always #20 mclk_i = ~mclk_i;
    // A hang is cut off at 5000 cycles, far above the hundred or so cycles the tests need.
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            failures++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_of_test
    // Reset for ten cycles, then leave two edges before the first request.
    task automatic rst_seq();
        @(posedge mclk_i) rst_i <= 1;
        opt <= 4'($urandom);
        repeat (10) @(posedge mclk_i);
        rst_i <= 0;
        repeat (2) @(posedge mclk_i) #1;
    endtask : rst_seq
    // One mode-register write; the model adds a cycle before the design takes it.
    task automatic wr_mode(input logic [2:0] c, input logic [4:0] n);
        @(posedge mclk_i) {req, code, sck} <= {1'b1, c, n};
        @(posedge mclk_i) req <= 0;
        @(posedge mclk_i) #1;
    endtask : wr_mode
    // One-cycle event pulses, checked just after the edge that takes them.
    task automatic ev(input wd_evt_t w, input wake_evt_t k, input logic cs);
        @(posedge mclk_i) {wd, wk, can_set} <= {w, k, cs};
        @(posedge mclk_i) {wd, wk, can_set} <= '0;
        #1;
    endtask : ev
    initial begin
        void'($urandom(32'h89f88cfd));
        rst_seq();
        `CHK("mode", MODE_STARTUP, mode)
        `CHK("src", SRC_POWER_ON, src)
        wr_mode(CODE_INIT_NORMAL, SPI_BITS);
        `CHK("mode", MODE_NORMAL, mode)
        `CHK("wd", WD_WINDOW, wdm)
        `CHK("can", 1'b0, can)
        ev($urandom % 2 ? 4'h8 : 4'h4, '0, 0);
        `CHK("mode", MODE_STARTUP, mode)
        `CHK("src", SRC_WD_TRIGGER, src)
        $display("test window fault done");
        rst_seq();
        wr_mode(CODE_INIT_NORMAL, 5'($urandom % 31 + 17)); // Any count but sixteen.
        `CHK("mode", MODE_RESTART, mode)
        `CHK("long", 1'b1, lr)
        wr_mode(CODE_INIT_NORMAL, SPI_BITS);
        `CHK("mode", MODE_NORMAL, mode)
        $display("test restart done");
        rst_seq();
        wr_mode(CODE_INIT_NORMAL, SPI_BITS);
        for (int i = 0; i < 3; i++) wr_mode(i == 1 ? CODE_FLASH_B : CODE_FLASH_A, SPI_BITS);
        `CHK("mode", MODE_STARTUP, mode)
        `CHK("src", SRC_FLASH_ENTRY, src)
        `CHK("prep", 1'b1, fp)
        wr_mode(CODE_INIT_FLASH, SPI_BITS);
        `CHK("mode", MODE_FLASH, mode)
        wr_mode(CODE_NORMAL, SPI_BITS);
        `CHK("src", SRC_WRONG_CODE, src)
        $display("test flash entry done");
        rst_seq();
        wr_mode(CODE_INIT_NORMAL, SPI_BITS);
        ev('0, '0, 1);
        `CHK("can", 1'b1, can)
        wr_mode(CODE_STANDBY, SPI_BITS);
        `CHK("mode", MODE_STANDBY, mode)
        `CHK("can", 1'b0, can)
        `CHK("wmax", opt[0], wmax)
        wr_mode(CODE_SLEEP, SPI_BITS);
        `CHK("mode", MODE_SLEEP, mode)
        `CHK("pins", 3'h1, {rail, oe_n, ext_oe})
        ev('0, 7'h40, 0);
        `CHK("mode", MODE_STARTUP, mode)
        `CHK("rail", 1'b1, rail)
        $display("test sleep done");
        rst_seq();
        @(posedge mclk_i) pull <= 1;
        for (int i = 0; i < 8 && mode !== MODE_RESTART; i++) @(posedge mclk_i);
        #1;
        `CHK("mode", MODE_RESTART, mode)
        $display("test line fall done");
        end_of_test();
    end
endmodule : system_mode_controller_tb
`default_nettype wire
